// ### hw/swpf_host.sv
`timescale 1ns/1ps
// Notes on behaviour
// - Address stays stable through whole write
// - Hold terminating control, address 10 ns after
// - Data valid 50 ns before, 5 ns after
// - Output gate kept high during writes
// - Write strobe low at least 80 ns
// - Keep selects inactive while supply rises; host blocks new accesses only while the interrupt is low, no recovery wait
module swpf_host
  import swpf_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              sys_rst,
  input  wire logic              req_valid,
  input  wire logic              req_write,
  input  wire logic [ADDR_W-1:0] req_addr,
  input  wire logic [DATA_W-1:0] req_wdata,
  output logic                   req_ready,
  output logic                   rsp_valid,
  output logic [DATA_W-1:0]      rsp_rdata,
  output logic                   rsp_dropped,
  output logic                   power_fail,
  input  wire logic              pf_int_n,
  output logic [ADDR_W-1:0]      address_bus,
  input  wire logic [DATA_W-1:0] data_bus_in,
  output logic [DATA_W-1:0]      data_bus_out,
  output logic                   data_bus_oe_n,
  output logic                   write_n,
  output logic                   select_low_n,
  output logic                   select_high,
  output logic                   gate_n
);
  swpf_state_t      state_reg;     // Sequencer state
  logic             is_write_reg;  // Current access is a write
  logic             pf_seen_reg;   // Interrupt seen during current access
  logic [DATA_W-1:0] wdata_reg;    // Write byte held for the whole cycle
  logic             tmr_load;      // Timer start
  logic [CNT_W-1:0] tmr_count;     // Timer length
  logic             pf_now;        // Interrupt pulled low

  swpf_timer_if tif ();

  swpf_timer u_timer (
    .clk     (clk),
    .sys_rst (sys_rst),
    .t       (tif.tmr)
  );

  assign tif.load  = tmr_load;
  assign tif.count = tmr_count;

  // Open-drain interrupt: low means supply failing
  assign pf_now     = !pf_int_n;
  assign power_fail = pf_now;

  // New request only when idle and supply good; the device ignores us otherwise
  assign req_ready = (state_reg == SWPF_IDLE) && !pf_now;

  // Sequencer
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_reg <= SWPF_IDLE;
    end else begin
      case (state_reg)
        SWPF_IDLE: begin
          if (req_valid && req_ready) begin
            // Gate goes high first so the device lets go of the bus
            state_reg <= req_write ? SWPF_GATE_OFF : SWPF_RSTROBE;
          end
        end
        SWPF_GATE_OFF: begin
          if (tif.done) begin
            state_reg <= SWPF_WSTROBE;
          end
        end
        SWPF_WSTROBE: begin
          if (tif.done) begin
            state_reg <= SWPF_WHOLD;
          end
        end
        SWPF_WHOLD: begin
          if (tif.done) begin
            state_reg <= SWPF_RECOVER;
          end
        end
        SWPF_RSTROBE: begin
          if (tif.done) begin
            state_reg <= SWPF_RECOVER;
          end
        end
        SWPF_RECOVER: begin
          if (tif.done) begin
            state_reg <= SWPF_IDLE;
          end
        end
        default: begin
          state_reg <= SWPF_IDLE;
        end
      endcase
    end
  end

  // Timer loads on each state entry except the return to idle
  always_comb begin
    tmr_load  = 1'b0;
    tmr_count = '0;
    case (state_reg)
      SWPF_IDLE: begin
        if (req_valid && req_ready) begin
          tmr_load  = 1'b1;
          tmr_count = req_write ? CNT_W'(CYC_GATE_Z) : CNT_W'(CYC_READ);
        end
      end
      SWPF_GATE_OFF: begin
        if (tif.done) begin
          tmr_load = 1'b1;
          // Strobe low covers both pulse width and data setup
          tmr_count = CNT_W'((CYC_STROBE > CYC_DSETUP) ? CYC_STROBE : CYC_DSETUP);
        end
      end
      SWPF_WSTROBE: begin
        if (tif.done) begin
          tmr_load  = 1'b1;
          tmr_count = CNT_W'(CYC_DHOLD);
        end
      end
      SWPF_WHOLD, SWPF_RSTROBE: begin
        if (tif.done) begin
          tmr_load  = 1'b1;
          tmr_count = CNT_W'(CYC_RECOVER);
        end
      end
      default: begin
        tmr_load  = 1'b0;
        tmr_count = '0;
      end
    endcase
  end

  // Address and write data latched once per access
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      address_bus  <= '0;
      wdata_reg    <= '0;
      is_write_reg <= 1'b0;
    end else if (req_valid && req_ready) begin
      address_bus  <= req_addr;
      wdata_reg    <= req_wdata;
      is_write_reg <= req_write;
    end
  end

  // Control pins; strobe alone frames writes, selects frame the access
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      write_n      <= RST_WRITE_N;
      select_low_n <= RST_SEL_LN;
      select_high  <= RST_SEL_H;
      gate_n       <= RST_GATE_N;
    end else begin
      // Selects stay active through hold so the strobe is the terminating edge
      select_low_n <= !((state_reg != SWPF_IDLE && state_reg != SWPF_RECOVER) ||
                        (state_reg == SWPF_IDLE && req_valid && req_ready)) ;
      select_high  <= (state_reg != SWPF_IDLE && state_reg != SWPF_RECOVER) ||
                      (state_reg == SWPF_IDLE && req_valid && req_ready);
      write_n      <= !((state_reg == SWPF_GATE_OFF && tif.done) ||
                        (state_reg == SWPF_WSTROBE && !tif.done));
      gate_n       <= !((state_reg == SWPF_IDLE && req_valid && req_ready && !req_write) ||
                        (state_reg == SWPF_RSTROBE && !tif.done));
    end
  end

  // Data drive: on from strobe fall through hold time
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      data_bus_out  <= '0;
      data_bus_oe_n <= 1'b1;
    end else begin
      data_bus_out  <= wdata_reg;
      data_bus_oe_n <= !((state_reg == SWPF_GATE_OFF && tif.done) ||
                         state_reg == SWPF_WSTROBE ||
                         (state_reg == SWPF_WHOLD && !tif.done));
    end
  end

  // Track interrupt over an access; such a write may be lost
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pf_seen_reg <= 1'b0;
    end else if (state_reg == SWPF_IDLE) begin
      pf_seen_reg <= 1'b0;
    end else if (pf_now) begin
      pf_seen_reg <= 1'b1;
    end
  end

  // Completion report; read data sampled at end of the read strobe
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rsp_valid   <= 1'b0;
      rsp_rdata   <= '0;
      rsp_dropped <= 1'b0;
    end else begin
      rsp_valid   <= (state_reg == SWPF_RECOVER) && tif.done;
      rsp_dropped <= (state_reg == SWPF_RECOVER) && tif.done && (pf_seen_reg || pf_now);
      if (state_reg == SWPF_RSTROBE && tif.done && !is_write_reg) begin
        rsp_rdata <= data_bus_in;
      end
    end
  end
endmodule

// ### hw/swpf_pkg.sv
package swpf_pkg;
  // Bus widths fixed by the device
  localparam int ADDR_W = 13;
  localparam int DATA_W = 8;
  // Clock period in picoseconds (25 MHz)
  localparam int CLK_PS = 40000;
  // Device timing, ns, fast grade
  localparam int T_SETUP_ADDR_NS = 0;   // Address before strobe falls
  localparam int T_STROBE_NS     = 80;  // Least strobe low time
  localparam int T_DATA_SETUP_NS = 50;  // Data before terminating edge
  localparam int T_DATA_HOLD_NS  = 5;   // Data after terminating edge
  localparam int T_RECOVER_NS    = 10;  // Address/strobe high after write
  localparam int T_GATE_Z_NS     = 40;  // Output gate high to bus released
  localparam int T_READ_NS       = 100; // Address to output valid
  // Least times round up to whole cycles, at least one
  function automatic int ns_to_cyc(input int ns);
    int c;
    c = (ns * 1000 + CLK_PS - 1) / CLK_PS;
    return (c < 1) ? 1 : c;
  endfunction
  localparam int CYC_STROBE  = ns_to_cyc(T_STROBE_NS);
  localparam int CYC_DSETUP  = ns_to_cyc(T_DATA_SETUP_NS);
  localparam int CYC_DHOLD   = ns_to_cyc(T_DATA_HOLD_NS);
  localparam int CYC_RECOVER = ns_to_cyc(T_RECOVER_NS);
  localparam int CYC_GATE_Z  = ns_to_cyc(T_GATE_Z_NS);
  localparam int CYC_READ    = ns_to_cyc(T_READ_NS) + 1;
  localparam int CNT_W       = 4;
  // Reset values of the pins: everything inactive
  localparam logic RST_WRITE_N  = 1'b1;
  localparam logic RST_SEL_LN   = 1'b1;
  localparam logic RST_SEL_H    = 1'b0;
  localparam logic RST_GATE_N   = 1'b1;
  // Sequencer states
  typedef enum logic [2:0] {
    SWPF_IDLE, SWPF_GATE_OFF, SWPF_WSTROBE, SWPF_WHOLD, SWPF_RSTROBE, SWPF_RECOVER
  } swpf_state_t;
endpackage

// ### hw/swpf_timer_if.sv
`timescale 1ns/1ps
// Load/expire handshake between sequencer and its wait timer
interface swpf_timer_if;
  logic                      load;  // Start a wait
  logic [swpf_pkg::CNT_W-1:0] count; // Cycles to wait
  logic                      done;  // Wait elapsed
  modport ctrl (output load, output count, input done);
  modport tmr  (input load, input count, output done);
endinterface

// ### hw/swpf_timer.sv
`timescale 1ns/1ps
module swpf_timer
  import swpf_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  swpf_timer_if.tmr t
);
  logic [CNT_W-1:0] cnt_reg; // Remaining cycles

  // Down counter, reloaded on request
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cnt_reg <= '0;
    end else if (t.load) begin
      cnt_reg <= t.count;
    end else if (cnt_reg != '0) begin
      cnt_reg <= cnt_reg - 4'h1;
    end
  end

  // Done once the count has run out; kept free of load so no loop forms with the sequencer
  assign t.done = (cnt_reg == '0);
endmodule

// ### test/swpf_monitor.sv
`timescale 1ns/1ps
module swpf_monitor
  import swpf_pkg::*;
(
  input wire logic              clk,
  input wire logic              sys_rst,
  input wire logic              req_ready,
  input wire logic              rsp_valid,
  input wire logic              power_fail,
  input wire logic              pf_int_n,
  input wire logic [ADDR_W-1:0] address_bus,
  input wire logic [DATA_W-1:0] data_bus_out,
  input wire logic              data_bus_oe_n,
  input wire logic              write_n,
  input wire logic              select_low_n,
  input wire logic              select_high,
  input wire logic              gate_n
);
  // One domain, so one clock and one reset for all
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  chk_write_selected: assert property (!write_n |-> !select_low_n && select_high)
    else $error("strobe low outside selection");
  chk_done_after_end: assert property (rsp_valid |-> write_n)
    else $error("done while strobe still low");
  chk_addr_steady: assert property (!select_low_n && $past(!select_low_n)
    |-> $stable(address_bus))
    else $error("address moved in access");
  chk_recover_hold: assert property ($rose(write_n) |=> write_n && $stable(address_bus))
    else $error("no hold after write end");
  chk_data_setup: assert property ($rose(write_n) |-> !$past(data_bus_oe_n, 3)
    && $past(data_bus_out, 3) == data_bus_out)
    else $error("data not set up before end");
  chk_data_hold: assert property ($rose(write_n)
    |-> !data_bus_oe_n && $stable(data_bus_out))
    else $error("data not held at end");
  chk_gate_off_write: assert property (!write_n |-> gate_n)
    else $error("output gate on in write");
  chk_no_contention: assert property (!gate_n |-> data_bus_oe_n)
    else $error("host drives while gate on");
  chk_strobe_width: assert property ($fell(write_n) |-> !write_n [*3])
    else $error("strobe pulse too short");
  chk_pf_follow: assert property ((power_fail == !pf_int_n)
    && (!power_fail || !req_ready))
    else $error("interrupt not reported");
  // Idle selects stay inactive while the interrupt reports the supply failing
  chk_no_start_pf: assert property (power_fail && select_low_n |=> select_low_n)
    else $error("access started during power fail");
  // Main traffic seen
  cov_write_end: cover property ($rose(write_n));
  cov_pf_write: cover property (power_fail && !write_n);
  cov_read_gate: cover property (!gate_n ##1 gate_n);
endmodule
bind swpf_host swpf_monitor swpf_monitor_inst (.clk, .sys_rst, .req_ready, .rsp_valid,
  .power_fail, .pf_int_n, .address_bus, .data_bus_out, .data_bus_oe_n, .write_n,
  .select_low_n, .select_high, .gate_n);

// ### test/swpf_sram_model.sv
`timescale 1ns/1ps
module swpf_sram_model
  import swpf_pkg::*;
#(
  parameter int DESEL_NS = 40,  // Shortened interrupt to deselect wait
  parameter int REC_NS   = 200  // Shortened power-up recovery
)(
  input  wire logic [ADDR_W-1:0] address_bus,
  input  wire logic [DATA_W-1:0] data_bus_out,
  input  wire logic              write_n,
  input  wire logic              select_low_n,
  input  wire logic              select_high,
  input  wire logic              gate_n,
  input  wire logic              supply_low,
  output logic [DATA_W-1:0]      data_bus_in,
  output logic                   pf_int_n
);
  logic [DATA_W-1:0] mem [2**ADDR_W];
  logic              desel = 1'b0;   // Power-fail deselect
  logic              sel;            // Selected and powered
  logic              wr;             // Write mode
  initial for (int i = 0; i < 2**ADDR_W; i++) mem[i] = 8'h00;
  assign sel = !select_low_n && select_high && !desel;
  assign wr = sel && !write_n;
  // Byte lands at first releasing control; blocked while deselected
  always @(negedge wr) if (!desel) mem[address_bus] = data_bus_out;
  // Released bus shows inverse, never the stored byte
  assign data_bus_in = (sel && write_n && !gate_n) ? mem[address_bus]
                                                   : ~mem[address_bus];
  // Open drain with pull-up: low only while supply is low
  assign pf_int_n = supply_low ? 1'b0 : 1'b1;
  always @(posedge supply_low) #(DESEL_NS) desel = supply_low;
  always @(negedge supply_low) #(REC_NS) desel = supply_low;
endmodule

// ### test/testbench.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin n_checks++; if ((g) !== (e)) begin failures++; \
  $display("wrong value %s expected %h seen %h", n, e, g); end end
module testbench;
  import swpf_pkg::*;
  logic              clk, sys_rst, req_valid, req_write, req_ready, rsp_valid, rsp_dropped;
  logic              power_fail, pf_int_n, data_bus_oe_n, write_n, supply_low;
  logic              select_low_n, select_high, gate_n;
  logic [ADDR_W-1:0] req_addr, address_bus, a;
  logic [DATA_W-1:0] req_wdata, rsp_rdata, data_bus_in, data_bus_out;
  int                seed = 32'he24e69dc;
  int                failures = 0, n_checks = 0, cycles = 0;
  int                ref_mem [2**ADDR_W]; // Expected contents
  swpf_host swpf_host_inst (.clk, .sys_rst, .req_valid, .req_write, .req_addr, .req_wdata,
    .req_ready, .rsp_valid, .rsp_rdata, .rsp_dropped, .power_fail, .pf_int_n, .address_bus,
    .data_bus_in, .data_bus_out, .data_bus_oe_n, .write_n, .select_low_n, .select_high, .gate_n);
  swpf_sram_model swpf_sram_model_inst (.address_bus, .data_bus_out, .write_n, .select_low_n,
    .select_high, .gate_n, .supply_low, .data_bus_in, .pf_int_n);
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic print_verdict();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // One access; hold request until taken, then wait for done
  task automatic acc(input logic w, input logic [ADDR_W-1:0] ad, input logic [DATA_W-1:0] d,
                     input logic drop);
    @(posedge clk);
    #1 req_valid = 1'b1;
    req_write = w;
    req_addr = ad;
    req_wdata = d;
    @(negedge clk);
    while (req_ready !== 1'b1) @(negedge clk);
    @(posedge clk);
    #1 req_valid = 1'b0;
    while (rsp_valid !== 1'b1) @(negedge clk);
    `CHK("dropped", drop, rsp_dropped)
    if (w && !drop) ref_mem[ad] = d;
    if (!w) `CHK("rdata", ref_mem[ad], rsp_rdata)
  endtask
  // Hang guard, well above the expected run
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      failures++;
      print_verdict();
    end
  end
  initial begin
    {req_valid, req_write, req_addr, req_wdata, supply_low} = '0;
    sys_rst = 1'b1;
    repeat (8) @(posedge clk);
    #1 sys_rst = 1'b0;
    // End addresses first, then random; back-to-back write and reads
    for (int i = 0; i < 24; i++) begin
      a = (i < 2) ? ADDR_W'(i * 8191) : ADDR_W'($random(seed));
      acc(1'b1, a, DATA_W'($random(seed)), 1'b0);
      acc(1'b0, a, 8'h00, 1'b0);
      acc(1'b0, ADDR_W'($random(seed)), 8'h00, 1'b0);
    end
    // Supply fails while a write is under way
    a = 13'h0abc;
    acc(1'b1, a, 8'h3c, 1'b0);
    fork
      acc(1'b1, a, 8'hc3, 1'b1);
      begin
        repeat (3) @(posedge clk);
        #1 supply_low = 1'b1;
      end
    join
    `CHK("power_fail", 1'b1, power_fail)
    `CHK("req_ready", 1'b0, req_ready)
    repeat (20) @(posedge clk);
    #1 supply_low = 1'b0;
    // Wait past recovery before touching the array
    repeat (10) @(posedge clk);
    acc(1'b0, a, 8'h00, 1'b0);
    print_verdict();
  end
endmodule
